// file: shared/compare_logic_pkg.sv
// Package: constants and types for the compare and logic datapath
`default_nettype none
package compare_logic_pkg;

    localparam int GROUPS = 4;
    localparam int REGS   = 8;
    localparam int REG_W  = 24;

    typedef logic [REG_W-1:0] word_type;

    typedef enum logic [3:0] {
        compare_immediate     = 4'h0,
        compare_full_register = 4'h1,
        compare_halfword      = 4'h2,
        compare_character     = 4'h3,
        test_under_mask       = 4'h4,
        xor_immediate         = 4'h5,
        xor_full_register     = 4'h6,
        xor_halfword          = 4'h7,
        xor_character         = 4'h8,
        or_immediate          = 4'h9,
        or_full_register      = 4'hA,
        or_halfword           = 4'hB,
        or_character          = 4'hC,
        subtract_character    = 4'hD
    } op_type;

    typedef enum logic {
        st_idle = 1'b0,
        st_exec = 1'b1
    } state_type;

    // Register byte offsets
    localparam logic [7:0] ADDR_INSTR  = 8'h00;
    localparam logic [7:0] ADDR_GROUP  = 8'h04;
    localparam logic [7:0] ADDR_FLAGS  = 8'h08;
    localparam logic [7:0] ADDR_INDEX  = 8'h0C;
    localparam logic [7:0] ADDR_DATA   = 8'h10;
    localparam logic [7:0] ADDR_BRANCH = 8'h14;

    // Instruction word fields
    localparam int OP_LSB       = 0;
    localparam int OP_W         = 4;
    localparam int DEST_LSB     = 4;
    localparam int DEST_SEL_BIT = 7;
    localparam int SRC_LSB      = 8;
    localparam int SRC_SEL_BIT  = 11;
    localparam int IMM_LSB      = 16;

    localparam logic [2:0]        WORD_SIZE    = 3'h2;
    localparam word_type          GPR_RESET    = 24'h000000;
    localparam logic [23:0]       INSTR_RESET  = 24'h000000;
    localparam logic [1:0]        GROUP_RESET  = 2'h0;
    localparam logic [2:0]        INDEX_RESET  = 3'h0;
    localparam logic [GROUPS-1:0] FLAG_RESET   = 4'h0;
    localparam logic [15:0]       BRANCH_RESET = 16'h0000;

endpackage : compare_logic_pkg
`default_nettype wire

// file: hdl/logic_compare_unit.sv
// Combinational operand unit: compares, masks, logic ops, character subtract
`timescale 1ns/1ps
`default_nettype none
module logic_compare_unit (
    input  wire logic [3:0]  op,
    input  wire logic [23:0] dest_val,
    input  wire logic [23:0] src_val,
    input  wire logic [7:0]  imm,
    input  wire logic        dest_sel,
    input  wire logic        src_sel,
    output logic      [23:0] result,
    output logic             write_en,
    output logic             set_flags,
    output logic             lower,
    output logic             equal
);

    // Byte X is [23:16], byte 0 is [15:8], byte 1 is [7:0]
    function automatic logic [7:0] pick(input logic [23:0] v, input logic s);
        return s ? v[7:0] : v[15:8];
    endfunction : pick

    function automatic logic [23:0] place(input logic [23:0] v, input logic s,
                                          input logic [7:0] b);
        return s ? {v[23:8], b} : {v[23:16], b, v[7:0]};
    endfunction : place

    logic [7:0]  dbyte;
    logic [7:0]  sbyte;
    logic [23:0] diff_all;
    logic [15:0] diff_lo;
    logic [23:0] fval;
    logic        logic_op;

    assign dbyte    = pick(dest_val, dest_sel);
    assign sbyte    = pick(src_val, src_sel);
    assign diff_all = dest_val - {16'h0000, sbyte};
    assign diff_lo  = dest_val[23:8] - {8'h00, sbyte};

    always_comb begin
        result    = dest_val;
        write_en  = 1'b0;
        set_flags = 1'b1;
        lower     = 1'b0;
        equal     = 1'b0;
        fval      = 24'h000000;
        logic_op  = 1'b1;
        unique case (compare_logic_pkg::op_type'(op))
            compare_logic_pkg::compare_immediate: begin
                logic_op = 1'b0;
                lower    = dbyte < imm;
                equal    = dbyte == imm;
            end
            compare_logic_pkg::compare_full_register: begin
                logic_op = 1'b0;
                lower    = dest_val < src_val;
                equal    = dest_val == src_val;
            end
            compare_logic_pkg::compare_halfword: begin
                logic_op = 1'b0;
                lower    = dest_val[15:0] < src_val[15:0];
                equal    = dest_val[15:0] == src_val[15:0];
            end
            compare_logic_pkg::compare_character: begin
                logic_op = 1'b0;
                lower    = dbyte < sbyte;
                equal    = dbyte == sbyte;
            end
            compare_logic_pkg::test_under_mask: begin
                fval = {16'h0000, dbyte & imm};
            end
            compare_logic_pkg::xor_immediate: begin
                fval     = {16'h0000, dbyte ^ imm};
                result   = place(dest_val, dest_sel, fval[7:0]);
                write_en = 1'b1;
            end
            compare_logic_pkg::xor_full_register: begin
                result   = dest_val ^ src_val;
                fval     = result;
                write_en = 1'b1;
            end
            compare_logic_pkg::xor_halfword: begin
                result   = {dest_val[23:16], dest_val[15:0] ^ src_val[15:0]};
                fval     = {8'h00, result[15:0]};
                write_en = 1'b1;
            end
            compare_logic_pkg::xor_character: begin
                fval     = {16'h0000, dbyte ^ sbyte};
                result   = place(dest_val, dest_sel, fval[7:0]);
                write_en = 1'b1;
            end
            compare_logic_pkg::or_immediate: begin
                fval     = {16'h0000, dbyte | imm};
                result   = place(dest_val, dest_sel, fval[7:0]);
                write_en = 1'b1;
            end
            compare_logic_pkg::or_full_register: begin
                result   = dest_val | src_val;
                fval     = result;
                write_en = 1'b1;
            end
            compare_logic_pkg::or_halfword: begin
                result   = {dest_val[23:16], dest_val[15:0] | src_val[15:0]};
                fval     = {8'h00, result[15:0]};
                write_en = 1'b1;
            end
            compare_logic_pkg::or_character: begin
                fval     = {16'h0000, dbyte | sbyte};
                result   = place(dest_val, dest_sel, fval[7:0]);
                write_en = 1'b1;
            end
            compare_logic_pkg::subtract_character: begin
                logic_op = 1'b0;
                write_en = 1'b1;
                // Byte X takes the borrow but never the flags
                if (dest_sel) begin
                    result = diff_all;
                    lower  = diff_all[15];
                    equal  = diff_all[15:0] == 16'h0000;
                end else begin
                    result = {diff_lo, dest_val[7:0]};
                    lower  = diff_lo[7];
                    equal  = diff_lo[7:0] == 8'h00;
                end
            end
            default: begin
                logic_op  = 1'b0;
                set_flags = 1'b0;
            end
        endcase
        if (logic_op) begin
            lower = |fval;
            equal = ~|fval;
        end
    end

endmodule : logic_compare_unit
`default_nettype wire

// file: hdl/compare_logic_alu.sv
// Compare and logic datapath with register groups, flags and AHB-Lite access
`timescale 1ns/1ps
`default_nettype none
module compare_logic_alu (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    output logic             lower_flag,
    output logic             equal_flag,
    output logic             branch_req,
    output logic      [15:0] branch_addr
);

    function automatic logic [2:0] odd_reg(input logic [2:0] field);
        return {field[1:0], 1'b1};
    endfunction : odd_reg

    compare_logic_pkg::state_type state;
    compare_logic_pkg::state_type next_state;
    compare_logic_pkg::op_type    op;
    compare_logic_pkg::word_type  gpr      [compare_logic_pkg::GROUPS][compare_logic_pkg::REGS];
    compare_logic_pkg::word_type  next_gpr [compare_logic_pkg::GROUPS][compare_logic_pkg::REGS];
    compare_logic_pkg::word_type  dest_val;
    compare_logic_pkg::word_type  src_val;
    compare_logic_pkg::word_type  alu_result;

    logic        ap_valid;
    logic        next_ap_valid;
    logic        ap_write;
    logic        next_ap_write;
    logic [7:0]  ap_addr;
    logic [7:0]  next_ap_addr;
    logic        rd_ok;
    logic        next_rd_ok;
    logic [31:0] next_rdata;
    logic        wr_done;
    logic [23:0] instr;
    logic [23:0] next_instr;
    logic [1:0]  group;
    logic [1:0]  next_group;
    logic [2:0]  idx;
    logic [2:0]  next_idx;
    logic [3:0]  lower_bits;
    logic [3:0]  next_lower_bits;
    logic [3:0]  equal_bits;
    logic [3:0]  next_equal_bits;
    logic        next_branch_req;
    logic [15:0] next_branch_addr;
    logic [2:0]  dest_field;
    logic [2:0]  src_field;
    logic [2:0]  dest_addr;
    logic [2:0]  src_addr;
    logic        dest_sel;
    logic        src_sel;
    logic [7:0]  imm;
    logic        odd_dest;
    logic        odd_src;
    logic        branch_cond;
    logic        exec;
    logic        alu_we;
    logic        alu_set;
    logic        alu_lower;
    logic        alu_equal;

    // Instruction decode
    assign op         = compare_logic_pkg::op_type'(
                            instr[compare_logic_pkg::OP_LSB +: compare_logic_pkg::OP_W]);
    assign dest_field = instr[compare_logic_pkg::DEST_LSB +: 3];
    assign src_field  = instr[compare_logic_pkg::SRC_LSB +: 3];
    assign dest_sel   = instr[compare_logic_pkg::DEST_SEL_BIT];
    assign src_sel    = instr[compare_logic_pkg::SRC_SEL_BIT];
    assign imm        = instr[compare_logic_pkg::IMM_LSB +: 8];
    assign exec       = state == compare_logic_pkg::st_exec;

    assign odd_src  = op inside {compare_logic_pkg::compare_character,
                                 compare_logic_pkg::xor_character,
                                 compare_logic_pkg::or_character,
                                 compare_logic_pkg::subtract_character};
    assign odd_dest = odd_src || op inside {compare_logic_pkg::compare_immediate,
                                            compare_logic_pkg::test_under_mask,
                                            compare_logic_pkg::xor_immediate,
                                            compare_logic_pkg::or_immediate};
    assign dest_addr = odd_dest ? odd_reg(dest_field) : dest_field;
    assign src_addr  = odd_src ? odd_reg(src_field) : src_field;
    assign dest_val  = gpr[group][dest_addr];
    assign src_val   = gpr[group][src_addr];

    assign branch_cond = dest_addr == 3'h0 &&
                         op inside {compare_logic_pkg::xor_full_register,
                                    compare_logic_pkg::xor_halfword,
                                    compare_logic_pkg::or_full_register,
                                    compare_logic_pkg::or_halfword};

    logic_compare_unit u_unit (
        .op       (instr[compare_logic_pkg::OP_LSB +: compare_logic_pkg::OP_W]),
        .dest_val (dest_val),
        .src_val  (src_val),
        .imm      (imm),
        .dest_sel (dest_sel),
        .src_sel  (src_sel),
        .result   (alu_result),
        .write_en (alu_we),
        .set_flags(alu_set),
        .lower    (alu_lower),
        .equal    (alu_equal)
    );

    // Bus slave; stalls while an instruction runs and one cycle for read data
    assign hreadyout = !exec && !(ap_valid && !ap_write && !rd_ok);
    assign hresp     = 1'b0;
    assign wr_done   = ap_valid && ap_write && hreadyout;

    always_comb begin
        next_ap_valid = ap_valid;
        next_ap_write = ap_write;
        next_ap_addr  = ap_addr;
        if (hready) begin
            next_ap_valid = hsel && htrans[1] && hsize == compare_logic_pkg::WORD_SIZE;
            next_ap_write = hwrite;
            next_ap_addr  = {haddr[7:2], 2'b00};
        end
        next_rd_ok = ap_valid && !ap_write && !hreadyout;
        // Sampled every stalled cycle so a late flag update is seen
        case (ap_addr)
            compare_logic_pkg::ADDR_INSTR:  next_rdata = {8'h00, instr};
            compare_logic_pkg::ADDR_GROUP:  next_rdata = {30'h0, group};
            compare_logic_pkg::ADDR_FLAGS:  next_rdata = {20'h00000, equal_bits, lower_bits,
                                                          2'b00, equal_flag, lower_flag};
            compare_logic_pkg::ADDR_INDEX:  next_rdata = {29'h0, idx};
            compare_logic_pkg::ADDR_DATA:   next_rdata = {8'h00, gpr[group][idx]};
            compare_logic_pkg::ADDR_BRANCH: next_rdata = {16'h0000, branch_addr};
            default:                        next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
            rd_ok    <= 1'b0;
            hrdata   <= 32'h00000000;
        end else begin
            ap_valid <= next_ap_valid;
            ap_write <= next_ap_write;
            ap_addr  <= next_ap_addr;
            rd_ok    <= next_rd_ok;
            hrdata   <= next_rdata;
        end
    end

    // Execution: one cycle, result and flags written together
    always_comb begin
        next_state       = state;
        next_instr       = instr;
        next_group       = group;
        next_idx         = idx;
        next_gpr         = gpr;
        next_lower_bits  = lower_bits;
        next_equal_bits  = equal_bits;
        next_branch_req  = 1'b0;
        next_branch_addr = branch_addr;
        unique case (state)
            compare_logic_pkg::st_idle: begin
                if (wr_done) begin
                    unique case (ap_addr)
                        compare_logic_pkg::ADDR_INSTR: begin
                            next_instr = hwdata[23:0];
                            next_state = compare_logic_pkg::st_exec;
                        end
                        compare_logic_pkg::ADDR_GROUP: next_group = hwdata[1:0];
                        compare_logic_pkg::ADDR_INDEX: next_idx = hwdata[2:0];
                        compare_logic_pkg::ADDR_DATA:  next_gpr[group][idx] = hwdata[23:0];
                        default: ;
                    endcase
                end
            end
            compare_logic_pkg::st_exec: begin
                next_state = compare_logic_pkg::st_idle;
                if (branch_cond) begin
                    next_branch_req  = 1'b1;
                    next_branch_addr = gpr[group][0][15:0];
                end else begin
                    if (alu_we) begin
                        next_gpr[group][dest_addr] = alu_result;
                    end
                    if (alu_set) begin
                        next_lower_bits[group] = alu_lower;
                        next_equal_bits[group] = alu_equal;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= compare_logic_pkg::st_idle;
            instr       <= compare_logic_pkg::INSTR_RESET;
            group       <= compare_logic_pkg::GROUP_RESET;
            idx         <= compare_logic_pkg::INDEX_RESET;
            lower_bits  <= compare_logic_pkg::FLAG_RESET;
            equal_bits  <= compare_logic_pkg::FLAG_RESET;
            branch_req  <= 1'b0;
            branch_addr <= compare_logic_pkg::BRANCH_RESET;
            for (int g = 0; g < compare_logic_pkg::GROUPS; g++) begin
                for (int r = 0; r < compare_logic_pkg::REGS; r++) begin
                    gpr[g][r] <= compare_logic_pkg::GPR_RESET;
                end
            end
        end else begin
            state       <= next_state;
            instr       <= next_instr;
            group       <= next_group;
            idx         <= next_idx;
            lower_bits  <= next_lower_bits;
            equal_bits  <= next_equal_bits;
            branch_req  <= next_branch_req;
            branch_addr <= next_branch_addr;
            gpr         <= next_gpr;
        end
    end

    // Sequencer sees the active group's pair only
    assign lower_flag = lower_bits[group];
    assign equal_flag = equal_bits[group];

    // Checks
    default clocking chk_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic [7:0]  chk_dbyte;
    logic [7:0]  chk_sbyte;
    logic [3:0]  chk_mask;
    logic [23:0] chk_diff;
    logic        chk_lt_imm;
    logic        chk_eq_imm;
    logic        chk_lt_full;
    logic        chk_eq_full;
    logic        chk_lt_half;
    logic        chk_xi_zero;
    logic        chk_sub_neg;
    logic        chk_lt_char;
    logic        chk_eq_char;

    assign chk_dbyte   = dest_sel ? dest_val[7:0] : dest_val[15:8];
    assign chk_sbyte   = src_sel ? src_val[7:0] : src_val[15:8];
    assign chk_mask    = 4'h1 << group;
    assign chk_diff    = dest_val - {16'h0000, chk_sbyte};
    assign chk_lt_imm  = chk_dbyte < imm;
    assign chk_eq_imm  = chk_dbyte == imm;
    assign chk_lt_full = dest_val < src_val;
    assign chk_eq_full = dest_val == src_val;
    assign chk_lt_half = dest_val[15:0] < src_val[15:0];
    assign chk_xi_zero = (chk_dbyte ^ imm) == 8'h00;
    assign chk_sub_neg = chk_diff[15];
    assign chk_lt_char = chk_dbyte < chk_sbyte;
    assign chk_eq_char = chk_dbyte == chk_sbyte;

    cmp_imm_a: assert property (
        exec && op == compare_logic_pkg::compare_immediate
        |=> lower_flag == $past(chk_lt_imm) && equal_flag == $past(chk_eq_imm))
        else $error("immediate compare flags wrong");

    odd_dest_a: assert property (
        exec && odd_dest |-> dest_addr[0])
        else $error("odd form picked an even register");

    odd_src_a: assert property (
        exec && odd_src |-> src_addr[0] && dest_addr[0])
        else $error("character form source not odd");

    cmp_full_a: assert property (
        exec && op == compare_logic_pkg::compare_full_register
        |-> !alu_we ##1 lower_flag == $past(chk_lt_full) && equal_flag == $past(chk_eq_full))
        else $error("full compare wrong or wrote a register");

    cmp_half_a: assert property (
        exec && op == compare_logic_pkg::compare_halfword
        |=> lower_flag == $past(chk_lt_half))
        else $error("halfword compare looked at byte X");

    cmp_char_a: assert property (
        exec && op == compare_logic_pkg::compare_character
        |=> lower_flag == $past(chk_lt_char) && equal_flag == $past(chk_eq_char))
        else $error("character compare flags wrong");

    test_keep_a: assert property (
        exec && op == compare_logic_pkg::test_under_mask |-> !alu_we)
        else $error("test under mask wrote the register");

    xor_imm_a: assert property (
        exec && op == compare_logic_pkg::xor_immediate
        |=> equal_flag == $past(chk_xi_zero) && lower_flag != equal_flag)
        else $error("immediate XOR flags wrong");

    branch_hold_a: assert property (
        exec && branch_cond
        |=> branch_req && $stable(lower_bits) && $stable(equal_bits) ##1 !branch_req)
        else $error("register 0 branch touched flags");

    sub_char_a: assert property (
        exec && op == compare_logic_pkg::subtract_character && dest_sel
        |=> lower_flag == $past(chk_sub_neg))
        else $error("character subtract sign wrong");

    group_only_a: assert property (
        exec |=> ((lower_bits ^ $past(lower_bits)) & ~$past(chk_mask)) == 4'h0)
        else $error("flags of an idle group changed");

    flag_time_a: assert property (
        $changed(lower_bits) || $changed(equal_bits) |-> $past(exec))
        else $error("flags changed outside an execute cycle");

endmodule : compare_logic_alu
`default_nettype wire

// file: dv/instruction_sequencer.sv
// Bus master model of the instruction sequencer
`timescale 1ns/1ps
`default_nettype none
module instruction_sequencer (
    input  wire logic        hclk,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    output logic             hsel = 1'b0,
    output logic      [31:0] haddr = 32'h0,
    output logic      [1:0]  htrans = 2'h0,
    output logic             hwrite = 1'b0,
    output logic      [2:0]  hsize = 3'h2,
    output logic      [31:0] hwdata = 32'h0
);
    // Waits on hreadyout alone; the bench watchdog ends a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        // Released data must not look still valid
        hwdata <= ~d;
    endtask : xfer
endmodule : instruction_sequencer
`default_nettype wire

// file: dv/compare_logic_alu_test.sv
// Self-checking bench: random instructions against a reference model
`timescale 1ns/1ps
`default_nettype none
module compare_logic_alu_test;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hreadyout, hsel, hwrite, lower_flag, equal_flag, hresp, branch_req;
    logic [31:0] br_seen = 32'h0, br_exp = 32'h0;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans, grp;
    logic [2:0]  hsize;
    logic [15:0] branch_addr;
    logic [23:0] rf [4][8];
    logic [3:0]  lf = 4'h0, ef = 4'h0;
    logic [31:0] seed = 32'h0000EE9B;
    int          bad_count = 0, samples_checked = 0;
    always #20 hclk = ~hclk;
    // Every cycle showing a pulse counts, an unknown one too
    always @(posedge hclk)
        if (hresetn && branch_req !== 1'b0)
            br_seen <= br_seen + 32'h1;
    compare_logic_alu dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .lower_flag(lower_flag),
        .equal_flag(equal_flag), .branch_req(branch_req), .branch_addr(branch_addr));
    instruction_sequencer seq (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] pick(logic [23:0] v, logic s);
        return s ? v[7:0] : v[15:8];
    endfunction : pick
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic test_done();
        $display("compared %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic put(input logic [1:0] g, input logic [2:0] i, input logic [23:0] v);
        grp = g;
        rf[g][i] = v;
        seq.xfer(1'b1, compare_logic_pkg::ADDR_GROUP, {30'h0, g}, q);
        seq.xfer(1'b1, compare_logic_pkg::ADDR_INDEX, {29'h0, i}, q);
        seq.xfer(1'b1, compare_logic_pkg::ADDR_DATA, {8'h0, v}, q);
    endtask : put
    task automatic run_op(input logic [23:0] ins);
        logic [3:0]  op;
        logic [2:0]  d, s;
        logic [23:0] dv, sv, r, m;
        logic [7:0]  x, y;
        logic        wide, lo, eq;
        op = ins[3:0];
        wide = op inside {4'h1, 4'h2, 4'h6, 4'h7, 4'hA, 4'hB};
        d = wide ? ins[6:4] : {ins[5:4], 1'b1};
        s = wide ? ins[10:8] : {ins[9:8], 1'b1};
        dv = rf[grp][d];
        sv = rf[grp][s];
        m = (op inside {4'h2, 4'h7, 4'hB}) ? 24'h00FFFF : 24'hFFFFFF;
        x = pick(dv, ins[7]);
        y = (op inside {4'h0, 4'h4, 4'h5, 4'h9}) ? ins[23:16] : pick(sv, ins[11]);
        r = 24'h0;
        case (op)
            4'h0, 4'h3: {lo, eq} = {x < y, x == y};
            4'h1, 4'h2: begin
                lo = (dv & m) < (sv & m);
                eq = (dv & m) == (sv & m);
            end
            4'hD: r = ins[7] ? dv - y : {dv[23:8] - y, dv[7:0]};
            4'h4: r = {16'h0, x & y};
            4'h5, 4'h8: r = {16'h0, x ^ y};
            4'h9, 4'hC: r = {16'h0, x | y};
            4'h6, 4'h7: r = (dv ^ sv) & m;
            4'hA, 4'hB: r = (dv | sv) & m;
            // Unused codes: no write, flags kept
            default: {lo, eq} = {lf[grp], ef[grp]};
        endcase
        if (op == 4'hD)
            {lo, eq} = {r[15], ins[7] ? r[15:0] == 0 : r[15:8] == 0};
        else if (op inside {[4'h4:4'hC]})
            {lo, eq} = {r != 0, r == 0};
        seq.xfer(1'b1, compare_logic_pkg::ADDR_INSTR, {8'h0, ins}, q);
        if (wide && op > 4'h5 && d == 3'h0) begin
            br_exp = br_exp + 32'h1;
            seq.xfer(1'b0, compare_logic_pkg::ADDR_BRANCH, 32'h0, q);
            check(q, {16'h0, dv[15:0]});
            check({16'h0, branch_addr}, {16'h0, dv[15:0]});
        end else begin
            case (op)
                4'h5, 4'h8, 4'h9, 4'hC:
                    dv = ins[7] ? {dv[23:8], r[7:0]} : {dv[23:16], r[7:0], dv[7:0]};
                4'h6, 4'h7, 4'hA, 4'hB, 4'hD: dv = (dv & ~m) | r;
                default: ;
            endcase
            rf[grp][d] = dv;
            lf[grp] = lo;
            ef[grp] = eq;
        end
        seq.xfer(1'b1, compare_logic_pkg::ADDR_INDEX, {29'h0, d}, q);
        seq.xfer(1'b0, compare_logic_pkg::ADDR_DATA, 32'h0, q);
        check(q, {8'h0, rf[grp][d]});
        check({30'h0, lower_flag, equal_flag}, {30'h0, lf[grp], ef[grp]});
        check({31'h0, hresp}, 32'h0);
        seq.xfer(1'b0, compare_logic_pkg::ADDR_FLAGS, 32'h0, q);
        check(q, {20'h0, ef, lf, 2'h0, ef[grp], lf[grp]});
        check(br_seen, br_exp);
    endtask : run_op
    initial begin
        #(20000 * 40);
        bad_count++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        seq.xfer(1'b1, compare_logic_pkg::ADDR_FLAGS, 32'hFFF3, q);
        seq.xfer(1'b0, compare_logic_pkg::ADDR_FLAGS, 32'h0, q);
        check(q, 32'h0);
        seq.xfer(1'b0, 8'h3C, 32'h0, q);
        check(q, 32'h0);
        $display("test reset and access done");
        for (int i = 0; i < 32; i++) begin
            q = rnd();
            put(2'(i / 8), 3'(i % 8), q[23:0]);
        end
        $display("test preload done");
        for (int n = 0; n < 200; n++) begin
            q = rnd();
            put(q[1:0], q[4:2], q[31:8]);
            q = rnd();
            run_op({q[31:24], 4'h0, q[11:4], q[3:0]});
        end
        $display("test random instructions done");
        test_done();
    end
endmodule : compare_logic_alu_test
`default_nettype wire
